// [aps_enc_model.sv]
// Quadrature encoder model driving both axes of the plausibility block
`default_nettype none
module aps_enc_model (
  input  wire logic                    core_clk_i, // Core clock
  input  wire logic                    rstn_i,     // Async reset, active low
  input  wire logic [aps_pkg::NAX-1:0] bad_i,      // Freeze track B per axis
  output logic      [aps_pkg::NAX-1:0] enc_a_o,    // Track A per axis
  output logic      [aps_pkg::NAX-1:0] enc_b_o,    // Track B per axis
  output logic      [aps_pkg::NAX-1:0] enc_z_o     // Index per axis
);
  import aps_pkg::*;
  logic [4:0] cnt;   // Step position, one step each two cycles
  wire  [1:0] ph;    // Quadrature phase
  wire        idx;   // Index step, once per 16 steps
  assign ph  = cnt[2:1];
  assign idx = (cnt[4:1] == 4'h0);
  // Free running position, restarts with the module
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
  // Gray sequence, B leads A by a quarter period
  // A frozen B gives unequal edge counts, as a broken track would
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enc_a_o <= '0;
      enc_b_o <= '0;
      enc_z_o <= '0;
    end else begin
      enc_a_o <= {NAX{ph[1]}};
      enc_b_o <= (enc_b_o & bad_i) | ({NAX{ph[1] ^ ph[0]}} & ~bad_i);
      enc_z_o <= {NAX{idx}};
    end
  end
endmodule : aps_enc_model
`default_nettype wire

// [aps_pkg.sv]
// Constants and types of the axis plausibility status block
`default_nettype none
package aps_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ    = 200_000_000;   // Core clock rate
  localparam int unsigned REACT_MS  = 16;            // Reaction allowance in ms
  localparam int unsigned REACT_CYC = CLK_HZ / 1000 * REACT_MS; // Cycles in allowance
  localparam int unsigned FLASH_MS  = 250;           // LED flash half period in ms
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS; // Cycles per half period
  // Widths
  localparam int NAX  = 2;                           // Number of axes
  localparam int AW   = 4;                           // Register index width
  localparam int DW   = 32;                          // Register data width
  localparam int CW   = 16;                          // Edge counter width
  localparam int TW   = 32;                          // Timer width
  localparam int LW   = 8;                           // Log code width
  // Register indices
  localparam logic [AW-1:0] ADDR_CTRL   = 4'h0;      // Run, axis enables, global reset
  localparam logic [AW-1:0] ADDR_MASK   = 4'h1;      // Interrupt mask
  localparam logic [AW-1:0] ADDR_STAT   = 4'h2;      // Sticky events, write one to clear
  localparam logic [AW-1:0] ADDR_STATE  = 4'h3;      // Live state
  localparam logic [AW-1:0] ADDR_RATIO0 = 4'h4;      // Axis 0 edges per index
  localparam logic [AW-1:0] ADDR_RATIO1 = 4'h5;      // Axis 1 edges per index
  localparam logic [AW-1:0] ADDR_LOG    = 4'h6;      // Last log code and count
  localparam logic [AW-1:0] ADDR_ID     = 4'h7;      // Module code
  // Control fields
  localparam int CTRL_RUN  = 0;                      // Run bit
  localparam int CTRL_AXEN = 1;                      // Axis enable field, NAX bits
  localparam int CTRL_GRST = 3;                      // Global reset, self clearing
  // Status fields
  localparam int ST_IMPL = 0;                        // Implausible per axis
  localparam int ST_LIM  = 2;                        // Limit trip per axis
  localparam int ST_INT  = 4;                        // Internal error
  localparam int ST_EXT  = 5;                        // External error
  localparam int ST_W    = 6;                        // Status width
  // Plausibility limits and values
  localparam logic [CW-1:0] DIFF_MAX   = 16'h0004;   // Allowed A/B edge difference
  localparam logic [CW-1:0] RATIO_RST  = 16'h0000;   // Zero disables index check
  localparam logic [15:0]   ID_VALUE   = 16'h5A3C;   // Arbitrary module code
  localparam logic [LW-1:0] LOG_INT    = 8'h10;      // Log code, internal error
  localparam logic [LW-1:0] LOG_EXT    = 8'h11;      // Log code, external error
  localparam logic [LW-1:0] LOG_IMPL   = 8'h01;      // Log code base, implausible axis
  localparam logic [TW-1:0] TMR_ONE    = 32'h0000_0001; // Timer step
  localparam logic [CW-1:0] CNT_ONE    = 16'h0001;   // Counter step
  // Axis state, one hot
  typedef enum logic [3:0] {
    AX_OFF  = 4'b0001,                               // Disabled or stopped
    AX_WAIT = 4'b0010,                               // Not yet ready
    AX_RUN  = 4'b0100,                               // Configured and running
    AX_BAD  = 4'b1000                                // Implausible signal
  } aps_axis_e;
endpackage : aps_pkg
`default_nettype wire

// [aps_top.sv]
// Axis plausibility, fault handling and status indication for two axes
// Operation
// - Implausible axis flags error, no system halt
// - Implausible signal lights LEDs and logs entry
// - Implausible error disables motion monitoring functions
// - Re-enable only by global reset, plausible signals
// - Detection latency may depend on error, frequency
// - React within input period plus 16 ms
// - Axis LED shows not ready, running, implausible
// - Internal error flashes fault, enters safe state
// - External error lights fault steady, safe state
// - Stopped and running idle shown on LEDs
// - Implausible lights diagnostic with axis LED
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module aps_top #(
  parameter int unsigned CHECK_CYC = aps_pkg::REACT_CYC, // Plausibility window
  parameter int unsigned FLASH_HALF = aps_pkg::FLASH_CYC // Flash half period
) (
  input  wire logic                     core_clk_i,  // Core clock
  input  wire logic                     rstn_i,      // Async reset, active low
  input  wire logic                     ce_i,        // Clock enable
  input  wire logic [aps_pkg::AW-1:0]   addr_i,      // Register index
  input  wire logic [aps_pkg::DW-1:0]   wdata_i,     // Write data
  input  wire logic                     wr_i,        // Write strobe
  input  wire logic                     rd_i,        // Read strobe
  output logic      [aps_pkg::DW-1:0]   rdata_o,     // Read data, next cycle
  input  wire logic [aps_pkg::NAX-1:0]  enc_a_i,     // Track A per axis
  input  wire logic [aps_pkg::NAX-1:0]  enc_b_i,     // Track B per axis
  input  wire logic [aps_pkg::NAX-1:0]  enc_z_i,     // Index track per axis
  input  wire logic [aps_pkg::NAX-1:0]  limit_exc_i, // Limit exceeded per axis
  input  wire logic                     int_err_i,   // Internal error
  input  wire logic                     ext_err_i,   // External error
  output logic      [aps_pkg::NAX-1:0]  motion_en_o, // Motion functions enabled
  output logic      [aps_pkg::NAX-1:0]  limit_trip_o, // Limit reaction taken
  output logic                          failsafe_halt_o, // Safe halt latched
  output logic                          power_led_o, // Power LED
  output logic                          run_led_o,   // Run LED
  output logic                          diag_led_o,  // Diagnostic LED
  output logic                          fault_led_o, // Fault LED
  output logic      [aps_pkg::NAX-1:0]  axis_led_o,  // Axis LEDs
  output logic                          log_wr_o,    // Log entry strobe
  output logic      [aps_pkg::LW-1:0]   log_code_o,  // Log entry code
  output logic                          irq_o        // Interrupt, level
);
  import aps_pkg::*;

  // Control and status registers
  logic            run;               // Run bit
  logic [NAX-1:0]  ax_en;             // Axis enables
  logic            grst;              // Global reset pulse
  logic [ST_W-1:0] stat;              // Sticky events
  logic [ST_W-1:0] mask;              // Interrupt mask
  logic [CW-1:0]   ratio [NAX];       // Edges per index per axis
  logic [CW-1:0]   log_cnt;           // Entries written
  logic            int_seen;          // Internal error latched
  logic            ext_seen;          // External error latched
  logic [TW-1:0]   win_cnt;           // Window timer
  logic [TW-1:0]   fl_cnt;            // Flash timer
  logic            flash;             // Flash phase
  logic [3:0]      log_pend;          // Pending log entries

  // Per axis state
  aps_axis_e       st      [NAX];     // Axis state
  aps_axis_e       next_st [NAX];     // Axis next state
  logic [NAX-1:0]  bad_evt;           // Implausible seen this cycle
  logic [NAX-1:0]  last_ok;           // Last window plausible
  logic [NAX-1:0]  bad_now;           // In bad state

  // Bus decode
  wire wr_ctrl  = wr_i && (addr_i == ADDR_CTRL);
  wire wr_mask  = wr_i && (addr_i == ADDR_MASK);
  wire wr_stat  = wr_i && (addr_i == ADDR_STAT);
  wire wr_r0    = wr_i && (addr_i == ADDR_RATIO0);
  wire wr_r1    = wr_i && (addr_i == ADDR_RATIO1);
  wire win_end  = (win_cnt == CHECK_CYC[TW-1:0] - TMR_ONE);
  wire next_halt = failsafe_halt_o | int_err_i | ext_err_i;
  wire [ST_W-1:0] evt = {ext_err_i, int_err_i, limit_exc_i, bad_evt};
  // Set wins over the write-one clear
  wire [ST_W-1:0] next_stat = (stat & ~(wr_stat ? wdata_i[ST_W-1:0] : '0)) | evt;
  wire [DW-1:0] state_word = {{(DW-12){1'b0}}, log_pend, ext_seen, int_seen,
                              failsafe_halt_o, run, motion_en_o, bad_now};
  wire [DW-1:0] rd_mux =
      (addr_i == ADDR_CTRL)   ? {{(DW-4){1'b0}}, 1'b0, ax_en, run} :
      (addr_i == ADDR_MASK)   ? {{(DW-ST_W){1'b0}}, mask} :
      (addr_i == ADDR_STAT)   ? {{(DW-ST_W){1'b0}}, stat} :
      (addr_i == ADDR_STATE)  ? state_word :
      (addr_i == ADDR_RATIO0) ? {{(DW-CW){1'b0}}, ratio[0]} :
      (addr_i == ADDR_RATIO1) ? {{(DW-CW){1'b0}}, ratio[1]} :
      (addr_i == ADDR_LOG)    ? {{(DW-CW-LW){1'b0}}, log_cnt, log_code_o} :
      (addr_i == ADDR_ID)     ? {{(DW-16){1'b0}}, ID_VALUE} : '0;

  // Register writes; global reset is a one cycle pulse
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run      <= 1'b0;
      ax_en    <= '0;
      grst     <= 1'b0;
      mask     <= '0;
      stat     <= '0;
      ratio[0] <= RATIO_RST;
      ratio[1] <= RATIO_RST;
      rdata_o  <= '0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        run   <= wdata_i[CTRL_RUN];
        ax_en <= wdata_i[CTRL_AXEN +: NAX];
      end
      grst <= wr_ctrl & wdata_i[CTRL_GRST];
      if (wr_mask) mask <= wdata_i[ST_W-1:0];
      if (wr_r0) ratio[0] <= wdata_i[CW-1:0];
      if (wr_r1) ratio[1] <= wdata_i[CW-1:0];
      stat    <= next_stat;
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  // Shared plausibility window and flash timers
  // window sets detection latency
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_cnt <= '0;
      fl_cnt  <= '0;
      flash   <= 1'b0;
    end else if (ce_i) begin
      win_cnt <= win_end ? '0 : win_cnt + TMR_ONE;
      if (fl_cnt == FLASH_HALF[TW-1:0] - TMR_ONE) begin
        fl_cnt <= '0;
        flash  <= ~flash;
      end else begin
        fl_cnt <= fl_cnt + TMR_ONE;
      end
    end
  end

  // Per axis track checking and state machine
  for (genvar i = 0; i < NAX; i++) begin : g_ax
    logic          a_q, b_q, z_q;     // Previous samples
    logic [CW-1:0] cnt_a, cnt_b;      // Edges in window
    logic [CW-1:0] cnt_idx;           // A edges since index
    logic          win_bad;           // Bad seen in window
    wire a_rise = enc_a_i[i] & ~a_q;
    wire b_rise = enc_b_i[i] & ~b_q;
    wire z_rise = enc_z_i[i] & ~z_q;
    wire [CW-1:0] diff = (cnt_a > cnt_b) ? cnt_a - cnt_b : cnt_b - cnt_a;
    // Trade-off: a window of edges tolerates phase drift, costs latency
    wire diff_bad  = win_end && (diff > DIFF_MAX);
    wire ratio_bad = z_rise && (ratio[i] != RATIO_RST) && (cnt_idx != ratio[i]);
    wire active    = run && ax_en[i];
    assign bad_evt[i] = active && (diff_bad || ratio_bad);
    assign bad_now[i] = (st[i] == AX_BAD);

    // Edge counting over the window
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        a_q        <= 1'b0;
        b_q        <= 1'b0;
        z_q        <= 1'b0;
        cnt_a      <= '0;
        cnt_b      <= '0;
        cnt_idx    <= '0;
        win_bad    <= 1'b0;
        last_ok[i] <= 1'b0;
      end else if (ce_i) begin
        a_q <= enc_a_i[i];
        b_q <= enc_b_i[i];
        z_q <= enc_z_i[i];
        cnt_a   <= win_end ? '0 : cnt_a + {{(CW-1){1'b0}}, a_rise};
        cnt_b   <= win_end ? '0 : cnt_b + {{(CW-1){1'b0}}, b_rise};
        cnt_idx <= z_rise ? '0 : cnt_idx + {{(CW-1){1'b0}}, a_rise};
        win_bad <= win_end ? 1'b0 : (win_bad | bad_evt[i]);
        // A bad event voids the evidence of the last clean window
        last_ok[i] <= win_end ? (active && !(win_bad || bad_evt[i]))
                              : (last_ok[i] && !bad_evt[i]);
      end
    end

    // Axis state transitions
    always_comb begin
      next_st[i] = st[i];
      case (st[i])
        AX_OFF:  if (active) next_st[i] = AX_WAIT;
        AX_WAIT: begin
          if (!active)         next_st[i] = AX_OFF;
          else if (bad_evt[i]) next_st[i] = AX_BAD;
          else if (win_end)    next_st[i] = AX_RUN;
        end
        AX_RUN: begin
          if (!active)         next_st[i] = AX_OFF;
          else if (bad_evt[i]) next_st[i] = AX_BAD;
        end
        // leave only on global reset with plausible window
        AX_BAD:  if (grst && last_ok[i]) next_st[i] = AX_RUN;
        default: next_st[i] = AX_OFF;
      endcase
    end

    // State, limit reaction and motion enable
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        st[i]           <= AX_OFF;
        limit_trip_o[i] <= 1'b0;
        motion_en_o[i]  <= 1'b0;
      end else if (ce_i) begin
        st[i] <= next_st[i];
        // limit reaction one cycle after it is seen
        limit_trip_o[i] <= limit_exc_i[i] | (limit_trip_o[i] & ~grst);
        // implausible or halt drops motion functions
        motion_en_o[i] <= (next_st[i] == AX_RUN) && !next_halt && !limit_exc_i[i]
                          && !(limit_trip_o[i] && !grst);
      end
    end
  end

  // Failure halt and error memory, cleared only by reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      failsafe_halt_o <= 1'b0;
      int_seen        <= 1'b0;
      ext_seen        <= 1'b0;
    end else if (ce_i) begin
      failsafe_halt_o <= next_halt;
      int_seen <= int_seen | int_err_i;
      ext_seen <= ext_seen | ext_err_i;
    end
  end

  // Error log, one entry per cycle, pending events kept
  // every new error gets a record
  // Only an axis newly entering the fault is logged, not every failing window
  wire [NAX-1:0] new_bad = bad_evt & ~bad_now;
  wire [3:0] next_pend = log_pend | {new_bad, ext_err_i & ~ext_seen, int_err_i & ~int_seen};
  wire [3:0] pick = next_pend & (~next_pend + 4'h1);
  wire [LW-1:0] pick_code = pick[0] ? LOG_INT : pick[1] ? LOG_EXT :
                            pick[2] ? LOG_IMPL : LOG_IMPL + 8'h01;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      log_pend   <= '0;
      log_wr_o   <= 1'b0;
      log_code_o <= '0;
      log_cnt    <= '0;
    end else if (ce_i) begin
      log_pend <= next_pend & ~pick;
      log_wr_o <= |next_pend;
      if (|next_pend) begin
        log_code_o <= pick_code;
        log_cnt    <= log_cnt + CNT_ONE;
      end
    end else begin
      log_wr_o <= 1'b0;
    end
  end

  // LED drive and interrupt
  wire any_bad = |bad_now;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_led_o <= 1'b0;
      run_led_o   <= 1'b0;
      diag_led_o  <= 1'b0;
      fault_led_o <= 1'b0;
      axis_led_o  <= '0;
      irq_o       <= 1'b0;
    end else if (ce_i) begin
      power_led_o <= 1'b1;
      // run LED off when stopped or halted
      run_led_o <= run && !next_halt;
      // diagnostic with axis LED on implausible
      diag_led_o <= any_bad;
      fault_led_o <= int_seen ? flash : ext_seen;
      // not ready flashes, running steady, bad flashes
      for (int k = 0; k < NAX; k++) begin
        axis_led_o[k] <= (st[k] == AX_RUN)  ? !int_seen :
                         (st[k] == AX_OFF)  ? (int_seen & flash) : flash;
      end
      irq_o <= |(next_stat & mask);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_halt_sticky:   assert property (failsafe_halt_o |=> failsafe_halt_o)
    else $error("halt dropped without reset");
  chk_halt_motion:   assert property (failsafe_halt_o |-> motion_en_o == '0)
    else $error("motion enabled during halt");
  chk_int_halt:      assert property (ce_i && int_err_i |=> failsafe_halt_o && int_seen)
    else $error("internal error did not halt");
  chk_ext_fault:     assert property (ce_i && ext_seen && !int_seen |=> fault_led_o)
    else $error("external fault LED not steady");
  chk_impl_nohalt:   assert property (ce_i && |bad_evt && !next_halt |=> !failsafe_halt_o)
    else $error("implausible signal halted system");
  chk_impl_disable:  assert property (st[0] == AX_BAD |-> !motion_en_o[0])
    else $error("axis 0 enabled while implausible");
  chk_impl_diag:     assert property (ce_i && st[0] == AX_BAD |=> diag_led_o)
    else $error("diagnostic LED off while implausible");
  chk_impl_log:      assert property (ce_i && bad_evt[0] && !bad_now[0]
    |=> log_wr_o && (log_code_o == LOG_IMPL || log_pend[2]))
    else $error("implausible signal not logged");
  chk_limit_react:   assert property (ce_i && limit_exc_i[0]
    |=> limit_trip_o[0] && !motion_en_o[0])
    else $error("limit reaction late");
  chk_rearm_grst:    assert property (st[1] == AX_BAD && !grst |=> st[1] == AX_BAD)
    else $error("axis left fault without global reset");
  chk_run_led:       assert property (failsafe_halt_o ##1 1'b1 |-> !run_led_o)
    else $error("run LED on during halt");

  cov_impl:   cover property (st[0] == AX_RUN ##1 st[0] == AX_BAD);
  cov_rearm:  cover property (st[0] == AX_BAD ##1 st[0] == AX_RUN);
  cov_halt:   cover property ($rose(failsafe_halt_o));
  cov_limit:  cover property (limit_exc_i[0] ##1 limit_trip_o[0]);
  cov_log:    cover property (log_wr_o && log_code_o == LOG_EXT);
endmodule : aps_top
`default_nettype wire

// [test_axis_plausibility_status.sv]
// Self-checking bench of the axis plausibility status block
`default_nettype none
module test_axis_plausibility_status;
  timeunit 1ns;
  timeprecision 100ps;
  import aps_pkg::*;
  localparam int CK = 64;                  // Short plausibility window
  logic            core_clk_i = 1'b0;      // Core clock
  logic            rstn_i = 1'b0;          // Reset, active low
  logic [AW-1:0]   addr_i = '0;            // Register index
  logic [DW-1:0]   wdata_i = '0;           // Write data
  logic            wr_i = 1'b0;            // Write strobe
  logic            rd_i = 1'b0;            // Read strobe
  logic [NAX-1:0]  bad = '0;               // Break track B per axis
  logic [NAX-1:0]  limit_exc_i = '0;       // Limit exceeded
  logic            int_err_i = 1'b0;       // Internal error
  logic            ext_err_i = 1'b0;       // External error
  wire  [DW-1:0]   rdata_o;                // Read data
  wire  [NAX-1:0]  enc_a, enc_b, enc_z;    // Encoder tracks
  wire  [NAX-1:0]  motion_en_o, limit_trip_o, axis_led_o; // Axis outputs
  wire             failsafe_halt_o, power_led_o, run_led_o; // Module state
  wire             diag_led_o, fault_led_o, log_wr_o, irq_o; // Indicators
  wire  [LW-1:0]   log_code_o;             // Log code
  int              miscompares = 0;        // Mismatch count
  int              num_checks = 0;         // Comparison count
  int              seed = 32'h1405;        // Random seed
  logic [DW-1:0]   v, r;                   // Bus scratch
  int              f, a0;                  // Sampled high counts
  logic [LW-1:0]   got_log[$];             // Log entries seen
  logic [LW-1:0]   exp_log[$];             // Log entries expected
  int              stat_exp = 0;           // Expected sticky status
  // Core clock, 200 MHz
  always #2.5 core_clk_i = ~core_clk_i;
  aps_top #(.CHECK_CYC(CK), .FLASH_HALF(4)) aps_top_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_z_i(enc_z), .limit_exc_i(limit_exc_i),
    .int_err_i(int_err_i), .ext_err_i(ext_err_i), .motion_en_o(motion_en_o),
    .limit_trip_o(limit_trip_o), .failsafe_halt_o(failsafe_halt_o),
    .power_led_o(power_led_o), .run_led_o(run_led_o), .diag_led_o(diag_led_o),
    .fault_led_o(fault_led_o), .axis_led_o(axis_led_o), .log_wr_o(log_wr_o),
    .log_code_o(log_code_o), .irq_o(irq_o));
  aps_enc_model aps_enc_model_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .bad_i(bad), .enc_a_o(enc_a), .enc_b_o(enc_b), .enc_z_o(enc_z));
  // Log strobe is high one cycle per entry, so sample every edge
  always @(posedge core_clk_i) begin
    if (log_wr_o === 1'b1) begin
      got_log.push_back(log_code_o);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd_reg
  task automatic wait_men(input int ax, input logic e, input int lim);
    int n;
    n = 0;
    #1;
    while (motion_en_o[ax] !== e && n < lim) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk(32'(motion_en_o[ax]), 32'(e));
  endtask : wait_men
  // Count high cycles of fault and axis 0 indicators over 16 cycles
  task automatic samp(output int fc, output int ac);
    fc = 0;
    ac = 0;
    repeat (16) begin
      @(posedge core_clk_i);
      #1;
      fc += int'(fault_led_o === 1'b1);
      ac += int'(axis_led_o[0] === 1'b1);
    end
  endtask : samp
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // Hang guard, far beyond the expected run
  initial begin
    #(CK * 200 * 5);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd_reg(ADDR_ID, r);
    chk(r, {16'h0000, ID_VALUE});
    rd_reg(4'h9, r);
    chk(r, 32'h0000_0000);
    v = $random(seed);
    wr_reg(ADDR_MASK, v);
    rd_reg(ADDR_MASK, r);
    chk(r, v & 32'h0000_003F);
    chk(32'({run_led_o, power_led_o}), 32'h1);
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(32'({run_led_o, power_led_o, motion_en_o, axis_led_o}), 32'h30);
    wr_reg(ADDR_CTRL, 32'h0000_0007);
    samp(f, a0);
    chk(32'(a0 > 0 && a0 < 16), 32'h1);
    wait_men(0, 1'b1, 3 * CK);
    samp(f, a0);
    chk({30'(a0), motion_en_o}, {30'd16, 2'b11});
    wr_reg(ADDR_MASK, 32'h0000_003F);
    bad <= 2'b01;
    wait_men(0, 1'b0, 3 * CK);
    exp_log.push_back(LOG_IMPL);
    stat_exp = 1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(32'({failsafe_halt_o, motion_en_o[1], diag_led_o, irq_o}), 32'h7);
    samp(f, a0);
    chk(32'(a0 > 0 && a0 < 16), 32'h1);
    rd_reg(ADDR_STAT, r);
    chk(r, 32'(stat_exp));
    wr_reg(ADDR_MASK, 32'h0000_003E);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(32'(irq_o), 32'h0);
    wr_reg(ADDR_CTRL, 32'h0000_000F);
    repeat (2 * CK) @(posedge core_clk_i);
    bad <= 2'b00;
    #1;
    chk(32'(motion_en_o[0]), 32'h0);
    repeat (2 * CK + 4) @(posedge core_clk_i);
    wr_reg(ADDR_CTRL, 32'h0000_000F);
    wait_men(0, 1'b1, 2 * CK);
    wr_reg(ADDR_STAT, 32'h0000_003F);
    stat_exp = 0;
    rd_reg(ADDR_STAT, r);
    chk(r, 32'(stat_exp));
    wr_reg(ADDR_RATIO1, 32'h0000_0005);
    wait_men(1, 1'b0, 2 * CK);
    exp_log.push_back(LOG_IMPL + 8'h01);
    wr_reg(ADDR_RATIO1, 32'h0000_0000);
    @(posedge core_clk_i);
    limit_exc_i <= 2'b01;
    repeat (2) @(posedge core_clk_i);
    ext_err_i <= 1'b1;
    #1;
    chk(32'({limit_trip_o[0], motion_en_o[0], failsafe_halt_o}), 32'h4);
    repeat (3) @(posedge core_clk_i);
    #1;
    exp_log.push_back(LOG_EXT);
    chk(32'({failsafe_halt_o, run_led_o, motion_en_o}), 32'h8);
    samp(f, a0);
    chk(32'(f), 32'd16);
    @(posedge core_clk_i);
    ext_err_i <= 1'b0;
    int_err_i <= 1'b1;
    exp_log.push_back(LOG_INT);
    repeat (3) @(posedge core_clk_i);
    samp(f, a0);
    chk(32'(f > 0 && f < 16), 32'h1);
    wr_reg(ADDR_CTRL, 32'h0000_000F);
    repeat (4) @(posedge core_clk_i);
    #1;
    chk(32'({failsafe_halt_o, motion_en_o}), 32'h4);
    chk(32'(got_log.size()), 32'(exp_log.size()));
    for (int i = 0; i < exp_log.size(); i++) begin
      chk(32'(got_log.size() > i ? got_log[i] : 8'hFF), 32'(exp_log[i]));
    end
    rd_reg(ADDR_LOG, r);
    chk(r, {8'h00, 16'(exp_log.size()), exp_log[$]});
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    int_err_i <= 1'b0;
    limit_exc_i <= 2'b00;
    #1;
    chk(32'({failsafe_halt_o, fault_led_o, motion_en_o}), 32'h0);
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(32'({failsafe_halt_o, power_led_o}), 32'h1);
    test_done();
  end
endmodule : test_axis_plausibility_status
`default_nettype wire
